// ===== circ_cnt_if.sv
`timescale 1ns/10ps
interface circ_cnt_if;
    import circ_pkg::*;
    logic                  inc_one;
    logic                  inc_big;
    logic                  dec_one;
    logic [CIRC_CNT_W-1:0] count;
    logic                  warn;
    logic                  passive;
    logic                  off;
    modport counter (input inc_one, inc_big, dec_one, output count, warn, passive, off);
    modport user    (output inc_one, inc_big, dec_one, input count, warn, passive, off);
endinterface

// ===== circ_core_model.sv
`timescale 1ns/10ps
module circ_core_model (
    // clock
    input  wire logic        sys_clk,
    // event pulses toward the block
    output logic      [63:0] mb_ev,
    output logic      [7:0]  core_ev,
    // sleep and bus sensing
    output logic             sleep_mode,
    output logic             bus_activity
);
    initial begin
        mb_ev = 64'h0;
        core_ev = 8'h0;
        sleep_mode = 1'b0;
        bus_activity = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // a quiet cycle between pulses, so back-to-back events stay countable
    task automatic fire(input int unsigned pos, input int unsigned n, input bit mb);
        repeat (n) begin
            @(posedge sys_clk);
            if (mb) begin
                mb_ev[pos] <= 1'b1;
            end else begin
                core_ev[pos] <= 1'b1;
            end
            @(posedge sys_clk);
            mb_ev <= 64'h0;
            core_ev <= 8'h0;
        end
    endtask
    task automatic set_sleep(input logic s, input logic a);
        @(posedge sys_clk);
        sleep_mode <= s;
        bus_activity <= a;
    endtask
endmodule // circ_core_model

// ===== circ_err_cnt.sv
`timescale 1ns/10ps
module circ_err_cnt
    import circ_pkg::*;
(
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       blk_rst,
    // count events and levels
    circ_cnt_if.counter    cnt
);
    logic [CIRC_CNT_W-1:0] cur_count;
    logic [CIRC_CNT_W-1:0] next_count;
    logic [CIRC_CNT_W:0]   up_sum;
    logic [CIRC_CNT_W-1:0] step;

    assign step       = cnt.inc_big ? CIRC_STEP_BIG : CIRC_STEP_ONE;
    assign up_sum     = {1'b0, cur_count} + {1'b0, step};
    // saturate so a stuck bus cannot wrap the count back to error active
    assign next_count = (cnt.inc_one || cnt.inc_big)
                      ? (up_sum[CIRC_CNT_W] ? CIRC_CNT_MAX : up_sum[CIRC_CNT_W-1:0])
                      : (cnt.dec_one && cur_count != CIRC_CNT_ZERO)
                      ? cur_count - CIRC_STEP_ONE : cur_count;

    always_ff @(posedge sys_clk) begin
        if (blk_rst) cur_count <= CIRC_CNT_ZERO;
        else         cur_count <= next_count;
    end

    assign cnt.count   = cur_count;
    assign cnt.warn    = cur_count >= CIRC_WARN_LVL;
    assign cnt.passive = cur_count >= CIRC_PASS_LVL;
    assign cnt.off     = cur_count >= CIRC_OFF_LVL;
endmodule // circ_err_cnt

// ===== circ_pkg.sv
package circ_pkg;
    localparam int         CIRC_CNT_W     = 9;
    localparam logic [8:0] CIRC_WARN_LVL  = 9'h060;
    localparam logic [8:0] CIRC_PASS_LVL  = 9'h080;
    localparam logic [8:0] CIRC_OFF_LVL   = 9'h100;
    localparam logic [8:0] CIRC_CNT_MAX   = 9'h1FF;
    localparam logic [8:0] CIRC_STEP_ONE  = 9'h001;
    localparam logic [8:0] CIRC_STEP_BIG  = 9'h008;
    localparam logic [8:0] CIRC_CNT_ZERO  = 9'h000;
    ////////////////////////////////////////////////////////////////////////////
    // register word offsets (word index, byte address bits 7:2)
    localparam logic [5:0] CIRC_OFF_FLAGS = 6'h00;
    localparam logic [5:0] CIRC_OFF_IMASK = 6'h01;
    localparam logic [5:0] CIRC_OFF_MBMSK = 6'h02;
    localparam logic [5:0] CIRC_OFF_IEN   = 6'h03;
    localparam logic [5:0] CIRC_OFF_CTRL  = 6'h04;
    localparam logic [5:0] CIRC_OFF_STAT  = 6'h05;
    localparam logic [5:0] CIRC_OFF_CNTS  = 6'h06;
    localparam logic [5:0] CIRC_OFF_RXP   = 6'h07;
    localparam logic [5:0] CIRC_OFF_RFP   = 6'h08;
    ////////////////////////////////////////////////////////////////////////////
    // flag bit positions
    localparam int F_RESET = 0;
    localparam int F_RXMSG = 1;
    localparam int F_REMOT = 2;
    localparam int F_TXWRN = 3;
    localparam int F_RXWRN = 4;
    localparam int F_PASS  = 5;
    localparam int F_BOFF  = 6;
    localparam int F_OVLD  = 7;
    localparam int F_EMPTY = 8;
    localparam int F_OVWR  = 9;
    localparam int F_WAKE  = 12;
    localparam logic [15:0] CIRC_ERR_GROUP = 16'h12FD;
    localparam logic [15:0] CIRC_FLAG_USED = 16'h13FF;
    localparam int C_RESET_REQ = 0;
    localparam int C_SLEEP_REQ = 5;
    localparam int S_BOFF  = 0;
    localparam int S_WARN  = 1;
    localparam int S_PASS  = 2;
    localparam int S_RSTST = 3;
    localparam logic [15:0] CIRC_FLAGS_RST = 16'h0001;
    localparam logic [15:0] CIRC_IMASK_RST = 16'hFFFF;
    localparam logic [15:0] CIRC_MBMSK_RST = 16'hFFFF;
    localparam logic [15:0] CIRC_CTRL_RST  = 16'h0001;
    localparam logic [15:0] CIRC_ZERO16    = 16'h0000;
    localparam logic [31:0] CIRC_ZERO32    = 32'h0000_0000;
    typedef enum logic {
        CIRC_BUS_IDLE = 1'b0,
        CIRC_BUS_DONE = 1'b1
    } circ_bus_state_t;
endpackage

// ===== circ_top.sv
`timescale 1ns/10ps
module circ_top
    import circ_pkg::*;
#(
    parameter int MB_N = 16
) (
    // clock and reset
    input  wire logic            sys_clk,
    input  wire logic            rst,
    // power states
    input  wire logic            module_stop_bit,
    input  wire logic            hw_standby,
    input  wire logic            sw_standby,
    input  wire logic            medium_speed,
    // avalon-mm slave
    input  wire logic [7:0]      avs_address,
    input  wire logic            avs_read,
    input  wire logic            avs_write,
    input  wire logic [31:0]     avs_writedata,
    input  wire logic [3:0]      avs_byteenable,
    output logic      [31:0]     avs_readdata,
    output logic                 avs_waitrequest,
    // protocol core events
    input  wire logic [MB_N-1:0] rx_done_mb,
    input  wire logic [MB_N-1:0] remote_rx_mb,
    input  wire logic [MB_N-1:0] tx_done_mb,
    input  wire logic [MB_N-1:0] tx_cancel_mb,
    input  wire logic            overload_tx,
    input  wire logic            unread_overwrite,
    input  wire logic            tx_err_big,
    input  wire logic            tx_ok,
    input  wire logic            rx_err_one,
    input  wire logic            rx_err_big,
    input  wire logic            rx_ok,
    input  wire logic            recessive_run,
    input  wire logic            sleep_mode,
    input  wire logic            bus_activity,
    // data transfer controller
    input  wire logic            dtc_enable,
    input  wire logic            dtc_done,
    output logic                 dtc_request,
    // control to protocol core
    output logic                 reset_request_bit,
    output logic                 sleep_request_bit,
    output logic                 bus_off_state,
    // interrupt lines
    output logic                 error_status_irq_line,
    output logic                 mb0_receive_irq_line,
    output logic                 mb_rest_receive_irq_line,
    output logic                 transmit_done_irq_line
);
    ////////////////////////////////////////////////////////////////////////////
    // block reset and access gate
    logic            blk_rst;
    logic            access_ok;
    assign blk_rst   = rst || module_stop_bit || hw_standby || sw_standby;
    assign access_ok = !module_stop_bit && !medium_speed;

    ////////////////////////////////////////////////////////////////////////////
    // error counters
    circ_cnt_if tx_cnt ();
    circ_cnt_if rx_cnt ();

    circ_err_cnt u_tx_cnt (
        .sys_clk (sys_clk),
        .blk_rst (blk_rst),
        .cnt     (tx_cnt.counter)
    );
    circ_err_cnt u_rx_cnt (
        .sys_clk (sys_clk),
        .blk_rst (blk_rst),
        .cnt     (rx_cnt.counter)
    );

    assign bus_off_state  = tx_cnt.off;
    assign tx_cnt.inc_one = 1'b0;
    assign tx_cnt.inc_big = tx_err_big && !bus_off_state;
    assign tx_cnt.dec_one = tx_ok && !bus_off_state;
    // in bus-off the receive count tracks runs of recessive bits instead
    assign rx_cnt.inc_one = bus_off_state ? recessive_run : rx_err_one;
    assign rx_cnt.inc_big = rx_err_big && !bus_off_state;
    assign rx_cnt.dec_one = rx_ok && !bus_off_state;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [15:0]     flags;
    logic [15:0]     imask;
    logic [15:0]     mbmask;
    logic            ien;
    logic [15:0]     ctrl;
    logic [MB_N-1:0] rx_pend;
    logic [MB_N-1:0] rf_pend;
    logic            was_txw;
    logic            was_rxw;
    logic            was_pass;
    logic            was_boff;

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: one wait state, data stands on the release edge
    circ_bus_state_t bus_state;
    circ_bus_state_t next_bus_state;
    logic            bus_req;
    logic            wr_take;
    logic [5:0]      word_idx;
    logic [15:0]     lane_mask;
    logic [15:0]     wdata;
    logic [15:0]     w1c;
    logic [31:0]     rd_mux;
    logic            hit_flags;
    logic            hit_imask;
    logic            hit_mbmsk;
    logic            hit_ien;
    logic            hit_ctrl;
    logic            hit_rxp;
    logic            hit_rfp;

    assign bus_req         = avs_read || avs_write;
    assign next_bus_state  = (bus_state == CIRC_BUS_IDLE && bus_req) ? CIRC_BUS_DONE
                                                                      : CIRC_BUS_IDLE;
    assign avs_waitrequest = bus_req && bus_state == CIRC_BUS_IDLE;
    assign word_idx        = avs_address[7:2];
    // upper lanes hold nothing writable, so only the low two byte enables matter
    assign lane_mask       = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wdata           = avs_writedata[15:0];
    assign wr_take         = avs_write && bus_state == CIRC_BUS_DONE && access_ok;
    assign w1c             = wdata & lane_mask;
    assign hit_flags       = wr_take && word_idx == CIRC_OFF_FLAGS;
    assign hit_imask       = wr_take && word_idx == CIRC_OFF_IMASK;
    assign hit_mbmsk       = wr_take && word_idx == CIRC_OFF_MBMSK;
    assign hit_ien         = wr_take && word_idx == CIRC_OFF_IEN;
    assign hit_ctrl        = wr_take && word_idx == CIRC_OFF_CTRL;
    assign hit_rxp         = wr_take && word_idx == CIRC_OFF_RXP;
    assign hit_rfp         = wr_take && word_idx == CIRC_OFF_RFP;

    always_ff @(posedge sys_clk) begin
        if (rst) bus_state <= CIRC_BUS_IDLE;
        else     bus_state <= next_bus_state;
    end

    always_comb begin
        case (word_idx)
            CIRC_OFF_FLAGS: rd_mux = {CIRC_ZERO16, flags};
            CIRC_OFF_IMASK: rd_mux = {CIRC_ZERO16, imask};
            CIRC_OFF_MBMSK: rd_mux = {CIRC_ZERO16, mbmask};
            CIRC_OFF_IEN:   rd_mux = {31'h0000_0000, ien};
            CIRC_OFF_CTRL:  rd_mux = {CIRC_ZERO16, ctrl};
            CIRC_OFF_STAT:  rd_mux = {28'h000_0000,
                                      reset_request_bit || sleep_mode,
                                      was_pass, was_txw || was_rxw, was_boff};
            CIRC_OFF_CNTS:  rd_mux = {7'h00, rx_cnt.count, 7'h00, tx_cnt.count};
            CIRC_OFF_RXP:   rd_mux = {CIRC_ZERO16, rx_pend};
            CIRC_OFF_RFP:   rd_mux = {CIRC_ZERO16, rf_pend};
            default:        rd_mux = CIRC_ZERO32;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst)                                              avs_readdata <= CIRC_ZERO32;
        else if (avs_read && bus_state == CIRC_BUS_IDLE)
            avs_readdata <= access_ok ? rd_mux : CIRC_ZERO32;
    end

    ////////////////////////////////////////////////////////////////////////////
    // control and mask registers
    always_ff @(posedge sys_clk) begin
        if (blk_rst) begin
            imask  <= CIRC_IMASK_RST;
            mbmask <= CIRC_MBMSK_RST;
            ien    <= 1'b0;
            ctrl   <= CIRC_CTRL_RST;
        end else begin
            if (hit_imask) imask  <= (imask & ~lane_mask) | (wdata & lane_mask);
            if (hit_mbmsk) mbmask <= (mbmask & ~lane_mask) | (wdata & lane_mask);
            if (hit_ien && avs_byteenable[0]) ien <= wdata[0];
            if (hit_ctrl)  ctrl   <= (ctrl & ~lane_mask) | (wdata & lane_mask);
        end
    end
    assign reset_request_bit = ctrl[C_RESET_REQ];
    assign sleep_request_bit = ctrl[C_SLEEP_REQ];

    ////////////////////////////////////////////////////////////////////////////
    // event sources, mailbox mask applied before any flag sees them
    logic [MB_N-1:0] rx_ev;
    logic [MB_N-1:0] rf_ev;
    logic [MB_N-1:0] empty_ev;
    logic [15:0]     flag_set;
    logic            txw_rise;
    logic            rxw_rise;
    logic            pass_now;
    logic            pass_rise;
    logic            boff_rise;

    assign rx_ev     = rx_done_mb & ~mbmask;
    assign rf_ev     = remote_rx_mb & ~mbmask;
    assign empty_ev  = (tx_done_mb | tx_cancel_mb) & ~mbmask;
    assign txw_rise  = tx_cnt.warn && !was_txw;
    assign rxw_rise  = rx_cnt.warn && !was_rxw;
    assign pass_now  = tx_cnt.passive || rx_cnt.passive;
    assign pass_rise = pass_now && !was_pass;
    assign boff_rise = tx_cnt.off && !was_boff;

    always_comb begin
        flag_set          = CIRC_ZERO16;
        flag_set[F_RXMSG] = |rx_ev;
        flag_set[F_REMOT] = |rf_ev;
        flag_set[F_TXWRN] = txw_rise;
        flag_set[F_RXWRN] = rxw_rise;
        flag_set[F_PASS]  = pass_rise;
        flag_set[F_BOFF]  = boff_rise;
        flag_set[F_OVLD]  = overload_tx;
        flag_set[F_EMPTY] = |empty_ev;
        flag_set[F_OVWR]  = unread_overwrite;
        flag_set[F_WAKE]  = sleep_mode && bus_activity;
    end

    always_ff @(posedge sys_clk) begin
        if (blk_rst) begin
            was_txw  <= 1'h0;
            was_rxw  <= 1'h0;
            was_pass <= 1'h0;
            was_boff <= 1'h0;
        end else begin
            was_txw  <= tx_cnt.warn;
            was_rxw  <= rx_cnt.warn;
            was_pass <= pass_now;
            was_boff <= tx_cnt.off;
        end
    end

    // reset value sets the reset flag on every release of the block reset
    always_ff @(posedge sys_clk) begin
        if (blk_rst) flags <= CIRC_FLAGS_RST;
        else         flags <= (flag_set | (flags & ~(hit_flags ? w1c : CIRC_ZERO16)))
                              & CIRC_FLAG_USED;
    end

    // set wins over both a software clear and a transfer-end clear
    always_ff @(posedge sys_clk) begin
        if (blk_rst) begin
            rx_pend <= '0;
            rf_pend <= '0;
        end else begin
            rx_pend <= rx_done_mb | (rx_pend & ~(hit_rxp ? w1c[MB_N-1:0] : '0));
            rf_pend <= remote_rx_mb | (rf_pend & ~(hit_rfp ? w1c[MB_N-1:0] : '0));
            if (dtc_done && dtc_enable && !rx_done_mb[0]) rx_pend[0] <= 1'b0;
            if (dtc_done && dtc_enable && !remote_rx_mb[0]) rf_pend[0] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt lines, purely combinational so they drop with the flag
    logic [15:0] flag_live;
    logic        rx_live;
    logic        mb0_live;
    logic        rest_live;

    assign flag_live  = flags & ~imask;
    assign rx_live    = flag_live[F_RXMSG] && ien;
    assign mb0_live   = (rx_pend[0] || rf_pend[0]) && !mbmask[0];
    assign rest_live  = |((rx_pend[MB_N-1:1] | rf_pend[MB_N-1:1]) & ~mbmask[MB_N-1:1]);
    // the reset flag bypasses the interrupt mask but not the line enable
    assign error_status_irq_line = ien && (flags[F_RESET]
                                   || |(flag_live & CIRC_ERR_GROUP));
    assign mb0_receive_irq_line     = rx_live && mb0_live && !dtc_enable;
    assign mb_rest_receive_irq_line = rx_live && rest_live;
    assign transmit_done_irq_line   = flag_live[F_EMPTY] && ien;
    assign dtc_request = dtc_enable && rx_pend[0] && !mbmask[0];

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (blk_rst);

    property p_passive;
        $rose(pass_now) |=> flags[F_PASS];
    endproperty
    a_passive: assert property (p_passive) else $error("passive flag not set");

    property p_busoff;
        $rose(tx_cnt.count >= CIRC_OFF_LVL) |=> flags[F_BOFF] && bus_off_state;
    endproperty
    a_busoff: assert property (p_busoff) else $error("bus-off flag not set");

    property p_rxwarn;
        rx_cnt.count == CIRC_WARN_LVL - CIRC_STEP_ONE && rx_cnt.inc_one && !rx_cnt.dec_one
            |=> ##1 flags[F_RXWRN];
    endproperty
    a_rxwarn: assert property (p_rxwarn) else $error("receive warning missed");

    property p_overload;
        overload_tx |=> flags[F_OVLD];
    endproperty
    a_overload: assert property (p_overload) else $error("overload flag lost");

    property p_reset_unmasked;
        flags[F_RESET] && ien |-> error_status_irq_line;
    endproperty
    a_reset_unmasked: assert property (p_reset_unmasked) else $error("reset flag masked");

    property p_dtc_quiet;
        dtc_enable |-> !mb0_receive_irq_line;
    endproperty
    a_dtc_quiet: assert property (p_dtc_quiet) else $error("cpu request with transfer");

    property p_dtc_clear;
        dtc_done && dtc_enable && !rx_done_mb[0] && !remote_rx_mb[0]
            |=> !rx_pend[0] && !rf_pend[0];
    endproperty
    a_dtc_clear: assert property (p_dtc_clear) else $error("mailbox 0 not cleared");

    property p_mask_mb;
        (rx_done_mb & mbmask) != '0 && rx_ev == '0 && !flags[F_RXMSG]
            && !hit_flags |=> !flags[F_RXMSG];
    endproperty
    a_mask_mb: assert property (p_mask_mb) else $error("masked mailbox set flag");

    property p_line_drop;
        (flags & ~imask & CIRC_ERR_GROUP) == CIRC_ZERO16 && !flags[F_RESET]
            |-> !error_status_irq_line;
    endproperty
    a_line_drop: assert property (p_line_drop) else $error("line held without flag");

    property p_w1c;
        hit_flags && w1c[F_OVLD] && !overload_tx |=> !flags[F_OVLD];
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear");

    property p_blocked;
        medium_speed && avs_write && bus_state == CIRC_BUS_DONE
            && word_idx == CIRC_OFF_IMASK |=> imask == $past(imask);
    endproperty
    a_blocked: assert property (p_blocked) else $error("write in medium speed");

    property p_wake;
        sleep_mode && bus_activity |=> flags[F_WAKE];
    endproperty
    a_wake: assert property (p_wake) else $error("wake flag not set");
endmodule // circ_top

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import circ_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  pwr = 4'h1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        dtc_enable = 1'b0;
    logic        dtc_done = 1'b0;
    logic        dtc_request;
    logic        bus_off_state;
    logic [3:0]  irq;
    logic        reset_req;
    logic        sleep_req;
    logic [63:0] mb_ev;
    logic [7:0]  core_ev;
    logic        sleep_mode;
    logic        bus_activity;
    logic [31:0] rd;
    logic [31:0] wd;
    integer      seed = 32'h986e;
    integer      mismatches = 0;
    integer      checked = 0;
    int          k;
    int          m;
    int          n;
    always #50 sys_clk = ~sys_clk;
    circ_core_model PM (.sys_clk, .mb_ev, .core_ev, .sleep_mode, .bus_activity);
    circ_top #(.MB_N(16)) DUT (
        .sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .dtc_enable, .dtc_done,
        .dtc_request, .bus_off_state, .sleep_mode, .bus_activity,
        .module_stop_bit(pwr[0]), .hw_standby(pwr[1]), .sw_standby(pwr[2]),
        .medium_speed(pwr[3]), .rx_done_mb(mb_ev[15:0]), .remote_rx_mb(mb_ev[31:16]),
        .tx_done_mb(mb_ev[47:32]), .tx_cancel_mb(mb_ev[63:48]), .overload_tx(core_ev[0]),
        .unread_overwrite(core_ev[1]), .tx_err_big(core_ev[2]), .tx_ok(core_ev[3]),
        .rx_err_one(core_ev[4]), .rx_err_big(core_ev[5]), .rx_ok(core_ev[6]),
        .recessive_run(core_ev[7]), .reset_request_bit(reset_req),
        .sleep_request_bit(sleep_req),
        .error_status_irq_line(irq[0]), .mb0_receive_irq_line(irq[1]),
        .mb_rest_receive_irq_line(irq[2]), .transmit_done_irq_line(irq[3])
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge sys_clk);
    endtask
    // request held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge sys_clk iff avs_waitrequest === 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        bus(1'b0, a, 32'h0);
        chk({16'h0, rd[15:0]}, {16'h0, exp});
    endtask
    task automatic ichk(input logic [3:0] exp);
        cyc(1);
        chk({28'h0, irq}, {28'h0, exp});
    endtask
    function automatic logic [15:0] exp_flag(input int e);
        return (e == 0) ? 16'h0002 : (e == 1) ? 16'h0004 : 16'h0100;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(20000);
        mismatches = mismatches + 1;
        close_out;
    end
    initial begin
        cyc(8);
        rst <= 1'b0;
        rchk(8'h00, 16'h0000);
        pwr <= 4'h0;
        rchk(8'h00, CIRC_FLAGS_RST);
        rchk(8'h04, CIRC_IMASK_RST);
        for (k = 0; k < 4; k++) begin
            wd = $random(seed);
            bus(1'b1, 8'h08, wd);
            rchk(8'h08, wd[15:0]);
        end
        avs_byteenable <= 4'h1;
        bus(1'b1, 8'h04, 32'h0);
        avs_byteenable <= 4'hF;
        rchk(8'h04, 16'hFF00);
        bus(1'b1, 8'h04, 32'hFFFF);
        bus(1'b1, 8'h0C, 32'h1);
        ichk(4'h1);
        bus(1'b1, 8'h00, 32'h1);
        ichk(4'h0);
        bus(1'b1, 8'h04, 32'h0);
        PM.fire(2, 11, 1'b0);
        rchk(8'h00, 16'h0000);
        PM.fire(2, 1, 1'b0);
        rchk(8'h00, 16'h0008);
        ichk(4'h1);
        bus(1'b1, 8'h04, 32'h8);
        ichk(4'h0);
        bus(1'b1, 8'h04, 32'h0);
        PM.fire(2, 4, 1'b0);
        rchk(8'h00, 16'h0028);
        PM.fire(2, 16, 1'b0);
        rchk(8'h00, 16'h0068);
        chk({31'h0, bus_off_state}, 32'h1);
        PM.fire(7, 95, 1'b0);
        rchk(8'h00, 16'h0068);
        PM.fire(7, 1, 1'b0);
        bus(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h0060_0100);
        PM.fire(0, 1, 1'b0);
        PM.fire(1, 1, 1'b0);
        rchk(8'h00, 16'h02F8);
        bus(1'b1, 8'h00, 32'hFFFF);
        rchk(8'h00, 16'h0000);
        // all mailboxes masked first, then all open
        for (m = 0; m < 2; m++) begin
            bus(1'b1, 8'h08, m ? 32'h0 : 32'hFFFF);
            for (n = 0; n < 4; n++) begin
                k = 1 + {$random(seed)} % 15;
                PM.fire(16 * n + k, 1, 1'b1);
                rchk(8'h00, m ? exp_flag(n) : 16'h0);
                bus(1'b1, 8'h00, 32'hFFFF);
            end
        end
        bus(1'b1, 8'h1C, 32'hFFFF);
        bus(1'b1, 8'h20, 32'hFFFF);
        PM.fire(0, 1, 1'b1);
        ichk(4'h2);
        PM.fire(k, 1, 1'b1);
        ichk(4'h6);
        bus(1'b1, 8'h00, 32'hFFFF);
        bus(1'b1, 8'h1C, 32'hFFFF);
        ichk(4'h0);
        dtc_enable <= 1'b1;
        PM.fire(0, 1, 1'b1);
        PM.fire(16, 1, 1'b1);
        cyc(1);
        chk({30'h0, irq[1], dtc_request}, 32'h1);
        dtc_done <= 1'b1;
        cyc(1);
        dtc_done <= 1'b0;
        rchk(8'h1C, 16'h0000);
        rchk(8'h20, 16'h0000);
        dtc_enable <= 1'b0;
        bus(1'b1, 8'h00, 32'hFFFF);
        rchk(8'h14, 16'h000F);
        bus(1'b1, 8'h10, 32'h0);
        PM.set_sleep(1'b1, 1'b1);
        rchk(8'h00, 16'h1000);
        chk({31'h0, rd[S_RSTST]}, 32'h0);
        bus(1'b0, 8'h14, 32'h0);
        chk({31'h0, rd[S_RSTST]}, 32'h1);
        PM.set_sleep(1'b0, 1'b0);
        pwr <= 4'h8;
        rchk(8'h14, 16'h0000);
        bus(1'b1, 8'h04, 32'h5A5A);
        pwr <= 4'h0;
        rchk(8'h04, 16'h0000);
        rchk(8'h3C, 16'h0000);
        for (m = 0; m < 3; m++) begin
            bus(1'b1, 8'h04, 32'h0);
            pwr <= 4'h1 << m;
            cyc(2);
            pwr <= 4'h0;
            rchk(8'h04, CIRC_IMASK_RST);
            rchk(8'h00, CIRC_FLAGS_RST);
        end
        chk({30'h0, reset_req, sleep_req}, 32'h2);
        // reset flag cleared before the line enable, so no stray request
        bus(1'b1, 8'h00, 32'h1);
        bus(1'b1, 8'h0C, 32'h1);
        ichk(4'h0);
        PM.fire(5, 12, 1'b0);
        PM.fire(6, 1, 1'b0);
        PM.fire(4, 1, 1'b0);
        PM.fire(2, 1, 1'b0);
        PM.fire(3, 1, 1'b0);
        bus(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h0060_0007);
        rchk(8'h00, 16'h0010);
        bus(1'b1, 8'h10, 32'h20);
        cyc(1);
        chk({30'h0, reset_req, sleep_req}, 32'h1);
        close_out;
    end
endmodule // tb_top
